// [hw/iqd_pkg.sv]
// Purpose: Shared constants and types for the instruction queue and decode block
// Assumes: One core clock, synchronous active-high reset
// Notes: Instruction records are abstract predecoded words with class fields
// Function
// - Queue holds up to 18 predecoded instructions and refuses writes unless six entries are free.
// - Queue delivers at most five instructions per cycle in program order.
// - One macro-fusion per cycle in 32-bit and compatibility mode, none in 64-bit.
// - Loop replay only for loop bodies smaller than 18 instructions.
// - Detected loop entries stay locked and replay until a misprediction.
// - During replay the cache, predictor and predecode may idle.
// - Replay delivery suffers no taken-branch, misalignment or prefix penalty.
// - Four decoders; the first accepts instructions of up to 4 micro-operations.
// - All decoders handle single micro-operation flows, fused and tracked ones too.
// - Flows over 4 micro-operations go to a sequencer giving 3 per cycle.
// - Macro-fusion makes two adjacent eligible instructions one slot.
// - Implicit stack pointer updates are computed inside the decoders.
// - PUSH, POP and RET each decode to exactly one micro-operation.
// - Micro-fusion merges one instruction's operations into one complex operation.
`default_nettype none
package iqd_pkg;
  localparam int IQD_DEPTH = 18;
  localparam int IQD_WR_MAX = 6;
  localparam int IQD_RD_MAX = 5;
  localparam int IQD_DECODERS = 4;
  localparam int IQD_CPLX_UOPS = 4;
  localparam int IQD_SEQ_UOPS = 3;
  localparam int IQD_TAG_W = 16;
  localparam logic [1:0] IQD_SP_NONE = 2'h0;
  localparam logic [1:0] IQD_SP_DEC = 2'h1;
  localparam logic [1:0] IQD_SP_INC = 2'h2;
  localparam logic [7:0] IQD_SP_STEP = 8'h08;
  localparam logic [7:0] IQD_SP_RESET = 8'h00;
  // Instruction word: [15:8] tag, [7:5] uop count-1, [4] fusible head,
  // [3] fusible tail, [2] memory form, [1:0] stack class
  localparam int IQD_F_UOPS = 5;
  localparam int IQD_F_FHEAD = 4;
  localparam int IQD_F_FTAIL = 3;
  localparam int IQD_F_MEM = 2;
  typedef enum logic [1:0] {IQD_MODE_LEGACY, IQD_MODE_COMPAT, IQD_MODE_LONG} iqd_mode_e;
  typedef enum logic [1:0] {IQD_ST_STREAM, IQD_ST_LOCKED, IQD_ST_SEQ} iqd_state_e;
endpackage
`default_nettype wire

// [hw/iqd_mem.sv]
// Purpose: Instruction queue storage with registered read ports
// Assumes: Write indices are distinct within a cycle
// Notes: Read data appear one cycle after the address
`default_nettype none
module iqd_mem
  import iqd_pkg::*;
#(
  parameter int WIDTH = IQD_TAG_W,
  parameter int DEPTH = IQD_DEPTH,
  parameter int WR_N = IQD_WR_MAX,
  parameter int RD_N = IQD_RD_MAX,
  parameter int AW = 5
) (
  input wire logic sys_clk,
  input wire logic [WR_N-1:0] wr_en,
  input wire logic [WR_N*AW-1:0] wr_addr,
  input wire logic [WR_N*WIDTH-1:0] wr_data,
  input wire logic [RD_N*AW-1:0] rd_addr,
  output logic [RD_N*WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < WR_N; i++) begin
      if (wr_en[i]) begin
        mem_q[wr_addr[i*AW +: AW]] <= wr_data[i*WIDTH +: WIDTH];
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < RD_N; g++) begin : g_rd
      always_ff @(posedge sys_clk) begin
        rd_data[g*WIDTH +: WIDTH] <= mem_q[rd_addr[g*AW +: AW]];
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [hw/iqd_top.sv]
// Purpose: Instruction queue with loop replay and four-way decode
// Assumes: Predecode and rename share sys_clk; mispredict is a one-cycle pulse
// Notes: Queue occupancy is counted from head; loop entries stay until released
`default_nettype none
module iqd_top
  import iqd_pkg::*;
#(
  parameter int W = IQD_TAG_W,
  parameter int AW = 5
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [2:0] pd_count,
  input wire logic [IQD_WR_MAX*W-1:0] pd_data,
  output logic pd_ready,
  output logic fetch_idle,
  input wire iqd_mode_e mode,
  input wire logic loop_detect,
  input wire logic [AW-1:0] loop_len,
  input wire logic mispredict,
  output logic [IQD_DECODERS-1:0] uop_valid,
  output logic [IQD_DECODERS*W-1:0] uop_tag,
  output logic [IQD_DECODERS-1:0] uop_fused_macro,
  output logic [IQD_DECODERS-1:0] uop_fused_micro,
  output logic [7:0] sp_offset,
  output logic loop_active,
  input wire logic ren_ready
);
  localparam logic [AW-1:0] DEPTH_A = AW'(IQD_DEPTH);
  iqd_state_e state_q;
  logic [AW-1:0] head_q, tail_q, count_q, lhead_q, lpos_q, llen_q;
  logic [AW:0] free_w;
  logic [2:0] take_n;
  logic [3:0] seq_left_q;
  logic [AW-1:0] lpos_nxt;
  logic lock_rd;
  logic [7:0] sp_q;
  logic [IQD_WR_MAX-1:0] wr_en;
  logic [IQD_WR_MAX*AW-1:0] wr_addr;
  logic [IQD_RD_MAX*AW-1:0] rd_addr;
  logic [IQD_RD_MAX*W-1:0] rd_data;
  logic [AW-1:0] rd_base;
  logic rd_valid_q;
  logic [2:0] rd_avail_q;
  // Two-entry output buffer so a rename stall loses no decoded group
  logic [IQD_DECODERS*(3*W)-1:0] buf_q [2];
  logic [1:0] buf_cnt_q;
  logic buf_rd_q, buf_wr_q;
  logic grp_push;
  logic [IQD_DECODERS*(3*W)-1:0] grp_d;

  function automatic logic [AW-1:0] wrap(input logic [AW-1:0] a, input logic [AW-1:0] b);
    logic [AW:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, DEPTH_A}) s = s - {1'b0, DEPTH_A};
    return s[AW-1:0];
  endfunction

  // Offset folded into the loop body; bounded loop covers a one-entry body
  function automatic logic [AW-1:0] loop_mod(input logic [AW-1:0] a, input logic [AW-1:0] len);
    logic [AW-1:0] r;
    r = a;
    for (int i = 0; i < IQD_DEPTH; i++) begin
      if (len != '0 && r >= len) r = r - len;
    end
    return r;
  endfunction

  // Free slots; predecode must not exceed six per cycle
  assign free_w = {1'b0, DEPTH_A} - {1'b0, count_q};
  assign pd_ready = (state_q != IQD_ST_LOCKED) && (free_w >= (AW+1)'(IQD_WR_MAX));
  assign fetch_idle = (state_q == IQD_ST_LOCKED);
  assign loop_active = (state_q == IQD_ST_LOCKED);
  assign sp_offset = sp_q;

  genvar g;
  generate
    for (g = 0; g < IQD_WR_MAX; g++) begin : g_wr
      assign wr_en[g] = pd_ready && (3'(g) < pd_count);
      assign wr_addr[g*AW +: AW] = wrap(tail_q, AW'(g));
    end
    for (g = 0; g < IQD_RD_MAX; g++) begin : g_ra
      assign rd_addr[g*AW +: AW] = lock_rd ?
        wrap(lhead_q, loop_mod(lpos_nxt + AW'(g), llen_q)) : wrap(rd_base, AW'(g));
    end
  endgenerate

  iqd_mem #(.WIDTH(W), .DEPTH(IQD_DEPTH), .WR_N(IQD_WR_MAX), .RD_N(IQD_RD_MAX),
    .AW(AW)) u_mem (
    .sys_clk(sys_clk),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(pd_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Read data register lands after this edge, so address the entries left after it
  // Locked replay wraps inside the loop, so taken branches cost nothing
  assign lock_rd = (state_q == IQD_ST_LOCKED) && !mispredict;
  assign lpos_nxt = loop_mod(lpos_q + AW'(take_n), llen_q);
  assign rd_base = (state_q == IQD_ST_LOCKED) ? head_q : wrap(head_q, AW'(take_n));

  // Decode of the fetched group: slot 0 complex, rest simple
  logic [2:0] used;
  logic [2:0] fused_cnt;
  always_comb begin
    logic [W-1:0] ins;
    logic [W-1:0] nxt;
    logic [2:0] u;
    logic [2:0] k;
    logic stop;
    ins = '0;
    nxt = '0;
    u = '0;
    k = '0;
    stop = 1'b0;
    used = '0;
    fused_cnt = '0;
    grp_d = '0;
    if (rd_valid_q && state_q != IQD_ST_SEQ) begin
      for (int s = 0; s < IQD_DECODERS; s++) begin
        if (!stop && (k < rd_avail_q)) begin
          ins = rd_data[k*W +: W];
          u = ins[IQD_F_UOPS +: 3];
          if (u >= 3'(IQD_CPLX_UOPS)) begin
            stop = 1'b1;
            if (s == 0) begin
              grp_d[0 +: W] = ins;
              k = k + 3'd1;
            end
          end else if (u != 3'd0 && s != 0) begin
            stop = 1'b1;
          end else begin
            grp_d[s*3*W +: W] = ins;
            grp_d[s*3*W + W +: W] = {{(W-1){1'b0}}, ins[IQD_F_MEM]};
            k = k + 3'd1;
            if (k < rd_avail_q && fused_cnt == 3'd0 && mode != IQD_MODE_LONG) begin
              nxt = rd_data[k*W +: W];
              if (ins[IQD_F_FHEAD] && nxt[IQD_F_FTAIL]) begin
                grp_d[s*3*W + 2*W +: W] = {{(W-1){1'b0}}, 1'b1};
                fused_cnt = 3'd1;
                k = k + 3'd1;
              end
            end
          end
        end
      end
      used = k;
    end
  end

  assign grp_push = (used != 3'd0) && (buf_cnt_q != 2'd2);
  assign take_n = grp_push ? used : 3'd0;

  // Queue pointers and occupancy
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      head_q <= '0;
      tail_q <= '0;
      count_q <= '0;
    end else begin
      tail_q <= wrap(tail_q, pd_ready ? AW'(pd_count) : '0);
      if (state_q != IQD_ST_LOCKED) begin
        head_q <= wrap(head_q, AW'(take_n));
        count_q <= count_q + (pd_ready ? AW'(pd_count) : '0) - AW'(take_n);
      end
    end
  end

  // Loop lock state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= IQD_ST_STREAM;
      lhead_q <= '0;
      lpos_q <= '0;
      llen_q <= '0;
      seq_left_q <= '0;
    end else begin
      case (state_q)
        IQD_ST_STREAM: begin
          if (loop_detect && loop_len != '0 && loop_len < DEPTH_A &&
              loop_len <= count_q - AW'(take_n)) begin
            state_q <= IQD_ST_LOCKED;
            lhead_q <= wrap(head_q, AW'(take_n));
            lpos_q <= '0;
            llen_q <= loop_len;
          end else if (grp_push && used == 3'd1 &&
                       grp_d[IQD_F_UOPS +: 3] >= 3'(IQD_CPLX_UOPS)) begin
            state_q <= IQD_ST_SEQ;
            seq_left_q <= {1'b0, grp_d[IQD_F_UOPS +: 3]} + 4'd1;
          end
        end
        IQD_ST_LOCKED: begin
          if (mispredict) begin
            state_q <= IQD_ST_STREAM;
          end else if (grp_push) begin
            lpos_q <= lpos_nxt;
          end
        end
        IQD_ST_SEQ: begin
          if (buf_cnt_q != 2'd2) begin
            seq_left_q <= (seq_left_q > 4'(IQD_SEQ_UOPS)) ?
              seq_left_q - 4'(IQD_SEQ_UOPS) : 4'd0;
            if (seq_left_q <= 4'(IQD_SEQ_UOPS)) state_q <= IQD_ST_STREAM;
          end
        end
        default: state_q <= IQD_ST_STREAM;
      endcase
    end
  end

  // Replay reads only the loop body; normal reads only what is stored
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_valid_q <= 1'b0;
      rd_avail_q <= '0;
    end else begin
      rd_valid_q <= !grp_push && rd_valid_q ? 1'b1 : (count_q > take_n);
      if (lock_rd) begin
        rd_avail_q <= 3'(IQD_RD_MAX);
      end else begin
        rd_avail_q <= (count_q - AW'(take_n) >= AW'(IQD_RD_MAX)) ?
          3'(IQD_RD_MAX) : 3'(count_q - AW'(take_n));
      end
    end
  end

  // Stack pointer tracker: no uop carries the update
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sp_q <= IQD_SP_RESET;
    end else if (grp_push) begin
      logic [7:0] acc;
      acc = sp_q;
      for (int s = 0; s < IQD_DECODERS; s++) begin
        case (grp_d[s*3*W +: 2])
          IQD_SP_DEC: acc = acc - IQD_SP_STEP;
          IQD_SP_INC: acc = acc + IQD_SP_STEP;
          default: acc = acc;
        endcase
      end
      sp_q <= acc;
    end
  end

  // Output buffer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      buf_cnt_q <= '0;
      buf_rd_q <= 1'b0;
      buf_wr_q <= 1'b0;
    end else begin
      if (grp_push) begin
        buf_q[buf_wr_q] <= grp_d;
        buf_wr_q <= !buf_wr_q;
      end
      if (buf_cnt_q != 2'd0 && ren_ready) buf_rd_q <= !buf_rd_q;
      buf_cnt_q <= buf_cnt_q + {1'b0, grp_push} - {1'b0, buf_cnt_q != 2'd0 && ren_ready};
    end
  end

  // One slot per uop: PUSH/POP/RET and fused pairs are single entries
  generate
    for (g = 0; g < IQD_DECODERS; g++) begin : g_out
      logic [3*W-1:0] slot;
      assign slot = buf_q[buf_rd_q][g*3*W +: 3*W];
      assign uop_tag[g*W +: W] = slot[W-1:0];
      assign uop_valid[g] = (buf_cnt_q != 2'd0) && (slot != '0);
      assign uop_fused_micro[g] = slot[W];
      assign uop_fused_macro[g] = slot[2*W];
    end
  endgenerate

  a_queue_bound: assert property (@(posedge sys_clk) disable iff (reset)
    count_q <= DEPTH_A) else $error("Queue overflow");
  a_ready_free: assert property (@(posedge sys_clk) disable iff (reset)
    pd_ready |-> free_w >= 6'd6) else $error("Ready without room");
  a_read_max: assert property (@(posedge sys_clk) disable iff (reset)
    used <= 3'd5) else $error("Too many taken");
  a_no_fuse64: assert property (@(posedge sys_clk) disable iff (reset)
    mode == IQD_MODE_LONG |-> fused_cnt == 3'd0) else $error("Fused in 64-bit");
  a_loop_small: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(loop_active) |-> llen_q < DEPTH_A) else $error("Loop too large");
  a_loop_hold: assert property (@(posedge sys_clk) disable iff (reset)
    loop_active && !mispredict |=> loop_active) else $error("Lock lost");
  a_idle_fetch: assert property (@(posedge sys_clk) disable iff (reset)
    loop_active |-> !pd_ready && fetch_idle) else $error("Fetch during replay");
  a_seq_rate: assert property (@(posedge sys_clk) disable iff (reset)
    state_q == IQD_ST_SEQ |-> used == 3'd0) else $error("Decode during sequencer");
  c_loop: cover property (@(posedge sys_clk) $rose(loop_active));
  c_fuse: cover property (@(posedge sys_clk) |uop_fused_macro);
  c_stall: cover property (@(posedge sys_clk) buf_cnt_q == 2'd2 && !ren_ready);
endmodule
`default_nettype wire

// [tb/iqd_partner.sv]
// Purpose: Predecode feeder and rename consumer model around the decode block
// Assumes: The bench pushes words into fifo in program order
// Notes: Idle data lines toggle so a stale word never passes for a fresh one
`default_nettype none
module iqd_partner
  import iqd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [1:0] stall,
  output logic [2:0] pd_count,
  output logic [IQD_WR_MAX*IQD_TAG_W-1:0] pd_data,
  input wire logic pd_ready,
  input wire logic [IQD_DECODERS-1:0] uop_valid,
  input wire logic [IQD_DECODERS*IQD_TAG_W-1:0] uop_tag,
  input wire logic [IQD_DECODERS-1:0] uop_fused_macro,
  input wire logic [IQD_DECODERS-1:0] uop_fused_micro,
  output logic ren_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] fifo[$];
  logic [17:0] got[$];
  logic tgl = 1'b0;
  int n;
  always @(posedge sys_clk) begin
    if (!reset && pd_ready && pd_count != 3'h0) begin
      for (int i = 0; i < int'(pd_count); i++) begin
        void'(fifo.pop_front());
      end
    end
    // Offer no more than one predecode line per cycle
    n = reset ? 0 : (fifo.size() > IQD_WR_MAX ? IQD_WR_MAX : fifo.size());
    pd_count <= 3'(n);
    pd_data <= reset ? '0 : ~pd_data;
    for (int i = 0; i < n; i++) begin
      pd_data[i*16 +: 16] <= fifo[i];
    end
    if (!reset && ren_ready) begin
      for (int i = 0; i < IQD_DECODERS; i++) begin
        if (uop_valid[i]) begin
          got.push_back({uop_fused_macro[i], uop_fused_micro[i], uop_tag[i*16 +: 16]});
        end
      end
    end
    tgl <= ~tgl;
    ren_ready <= (stall == 2'h0) || (stall == 2'h1 && tgl);
  end
endmodule
`default_nettype wire

// [tb/iqd_top_tb_top.sv]
// Purpose: Self-checking bench for the queue, loop replay and decode block
// Assumes: Word tags are unique so order shows in the tag byte
// Notes: Every scenario starts from reset since queue state after a loop is open
`default_nettype none
module iqd_top_tb_top;
  import iqd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk;
  logic reset;
  logic loop_detect;
  logic mispredict;
  logic [4:0] loop_len;
  logic [1:0] stall;
  iqd_mode_e mode;
  logic [2:0] pd_count;
  logic [IQD_WR_MAX*IQD_TAG_W-1:0] pd_data;
  logic pd_ready;
  logic fetch_idle;
  logic loop_active;
  logic ren_ready;
  logic [7:0] sp_offset;
  logic [3:0] uop_valid;
  logic [3:0] uop_fused_macro;
  logic [3:0] uop_fused_micro;
  logic [63:0] uop_tag;
  int num_errors = 0;
  int n_tests = 0;
  iqd_top i_dut (.sys_clk, .reset, .pd_count, .pd_data, .pd_ready, .fetch_idle, .mode,
    .loop_detect, .loop_len, .mispredict, .uop_valid, .uop_tag, .uop_fused_macro,
    .uop_fused_micro, .sp_offset, .loop_active, .ren_ready);
  iqd_partner p (.sys_clk, .reset, .stall, .pd_count, .pd_data, .pd_ready, .uop_valid,
    .uop_tag, .uop_fused_macro, .uop_fused_micro, .ren_ready);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rst(input iqd_mode_e m, input logic [1:0] s);
    @(posedge sys_clk);
    reset <= 1'b1;
    mode <= m;
    stall <= s;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    p.fifo.delete();
    p.got.delete();
    chk({pd_ready, uop_valid, sp_offset, loop_active}, {1'b1, 4'h0, 8'h00, 1'b0});
  endtask
  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (p.got.size() < n && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (8) @(posedge sys_clk);
    #1;
    chk(p.got.size(), n);
  endtask
  task automatic pulse_detect(input logic [4:0] len);
    @(posedge sys_clk);
    loop_detect <= 1'b1;
    loop_len <= len;
    @(posedge sys_clk);
    loop_detect <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_order();
    rst(IQD_MODE_LEGACY, 2'h1);
    for (int i = 1; i <= 13; i++) p.fifo.push_back({8'(i), 8'h00});
    wait_got(13);
    for (int i = 0; i < 13; i++) chk(p.got[i], {2'b00, 8'(i + 1), 8'h00});
  endtask
  task automatic t_fuse(input iqd_mode_e m);
    rst(m, 2'h0);
    p.fifo.push_back({8'h21, 8'h10});
    p.fifo.push_back({8'h22, 8'h08});
    p.fifo.push_back({8'h23, 8'h00});
    wait_got(m == IQD_MODE_LONG ? 3 : 2);
    chk(p.got[0][17], m != IQD_MODE_LONG);
    chk(p.got[p.got.size() - 1][15:8], 8'h23);
  endtask
  task automatic t_track();
    rst(IQD_MODE_COMPAT, 2'h1);
    p.fifo.push_back({8'h31, 8'h01});
    p.fifo.push_back({8'h32, 8'h01});
    p.fifo.push_back({8'h33, 8'h02});
    p.fifo.push_back({8'h34, 8'h04});
    wait_got(4);
    chk(sp_offset, 8'hf8);
    chk(p.got[3][16], 1'b1);
    chk(p.got[2][16], 1'b0);
  endtask
  task automatic t_cplx();
    rst(IQD_MODE_LEGACY, 2'h0);
    p.fifo.push_back({8'h51, 8'h60});
    p.fifo.push_back({8'h52, 8'h80});
    p.fifo.push_back({8'h53, 8'h00});
    repeat (40) @(posedge sys_clk);
    #1;
    chk(p.got[0][15:8], 8'h51);
    chk(p.got[p.got.size() - 1][15:8], 8'h53);
  endtask
  task automatic t_loop();
    int sz;
    rst(IQD_MODE_LEGACY, 2'h2);
    for (int i = 0; i < 30; i++) p.fifo.push_back({8'(8'h40 + i), 8'h00});
    repeat (20) @(posedge sys_clk);
    #1;
    chk(pd_ready, 1'b0);
    pulse_detect(5'd18);
    chk(loop_active, 1'b0);
    pulse_detect(5'd4);
    chk({loop_active, fetch_idle, pd_ready}, 3'b110);
    sz = p.fifo.size();
    @(posedge sys_clk);
    stall <= 2'h0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(p.got.size() > 0, 1'b1);
    repeat (30) @(posedge sys_clk);
    #1;
    chk(p.got.size() >= 24, 1'b1);
    chk(p.fifo.size(), sz);
    for (int i = 8; i < 20; i++) begin
      chk(p.got[i + 4], p.got[i]);
      chk(p.got[i] !== p.got[i + 1], 1'b1);
    end
    @(posedge sys_clk);
    mispredict <= 1'b1;
    @(posedge sys_clk);
    mispredict <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk({loop_active, fetch_idle}, 2'b00);
  endtask
  initial begin
    reset = 1'b1;
    loop_detect = 1'b0;
    mispredict = 1'b0;
    loop_len = 5'h00;
    stall = 2'h0;
    mode = IQD_MODE_LEGACY;
    t_order();
    for (int m = 0; m < 3; m++) t_fuse(iqd_mode_e'(m));
    t_track();
    t_cplx();
    t_loop();
    results();
  end
  initial begin
    // Whole run needs well under 2000 cycles
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
